// *** rtl/cei_params.svh ***
// Constants for the custom and external interrupt configuration block
// Functional notes
// - Trigger register ignores host port writes
// - Sequencer write one raises custom interrupt
// - Trigger register resets to 0x00000010
// - Configuration registers reset to zero
// - Enable bit gates interrupt and wake
// - Mode codes select edge or level
// - Mode codes 5..7 alias codes 1..3
// - Config0 holds interrupts 3..0 in nibbles
// - Clear register resets 0xC000, host RW
// - Interrupt 0 in lowest nibble of config0
// - Config1 holds interrupts 7..4 same layout
// - Custom 0..2 report as flags 9..11
`ifndef CEI_PARAMS_SVH
`define CEI_PARAMS_SVH
`define CEI_OFS_CFG0 16'h0a20
`define CEI_OFS_CFG1 16'h0a24
`define CEI_OFS_CFG2 16'h0a28
`define CEI_OFS_CLR 16'h0a30
`define CEI_OFS_TRIG 16'h209c
`define CEI_RST_CFG 16'h0000
`define CEI_RST_CLR 16'hc000
`define CEI_RST_TRIG 32'h00000010
`define CEI_NUM_PINS 12
`define CEI_NUM_SOFT 4
`define CEI_FLAG_SOFT0 9
`endif

// *** rtl/cei_pkg.sv ***
// Types for the custom and external interrupt configuration block
package cei_pkg;
    // Trigger mode codes of one pin nibble
    typedef enum logic [2:0] {
        CEI_RISE = 3'h0,
        CEI_FALL = 3'h1,
        CEI_BOTH = 3'h2,
        CEI_HIGH = 3'h3,
        CEI_LOW = 3'h4,
        CEI_FALL_A = 3'h5,
        CEI_BOTH_A = 3'h6,
        CEI_HIGH_A = 3'h7
    } cei_mode_t;
    // One register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } cei_req_t;
endpackage : cei_pkg

// *** rtl/cei_top.sv ***
// Custom interrupt trigger register and external interrupt configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "cei_params.svh"
module cei_top (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire cei_pkg::cei_req_t host_req_i,
    input wire cei_pkg::cei_req_t seq_req_i,
    input wire logic [11:0] gpio_i,
    output logic [31:0] host_rdata_o,
    output logic [31:0] seq_rdata_o,
    output logic [11:0] ext_irq_o,
    output logic wake_o,
    output logic [3:0] soft_irq_o,
    output logic [2:0] flag_custom_o
);
    import cei_pkg::*;

    // Reset release synchroniser
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Configuration and clear registers
    logic [15:0] ext_irq_cfg0;
    logic [15:0] ext_irq_cfg1;
    logic [15:0] ext_irq_cfg2;
    logic [15:0] ext_irq_clear;
    // Custom bits; upper field is a constant
    logic [3:0] custom_irq_trigger;

    // Address decode, host port
    wire h_cfg0 = host_req_i.addr == `CEI_OFS_CFG0;
    wire h_cfg1 = host_req_i.addr == `CEI_OFS_CFG1;
    wire h_cfg2 = host_req_i.addr == `CEI_OFS_CFG2;
    wire h_clr = host_req_i.addr == `CEI_OFS_CLR;
    // Sequencer port sees the same map plus the trigger register
    wire s_cfg0 = seq_req_i.addr == `CEI_OFS_CFG0;
    wire s_cfg1 = seq_req_i.addr == `CEI_OFS_CFG1;
    wire s_cfg2 = seq_req_i.addr == `CEI_OFS_CFG2;
    wire s_clr = seq_req_i.addr == `CEI_OFS_CLR;
    wire s_trig = seq_req_i.addr == `CEI_OFS_TRIG;
    // Only the sequencer can hit the trigger register
    wire trig_wr = seq_req_i.wr && s_trig;
    wire [3:0] trig_set = trig_wr ? seq_req_i.wdata[3:0] : 4'h0;
    wire [31:0] trig_word = {28'h0000001, custom_irq_trigger};

    // Host wins when both ports write one register in a cycle
    wire wr0 = (host_req_i.wr && h_cfg0) || (seq_req_i.wr && s_cfg0);
    wire wr1 = (host_req_i.wr && h_cfg1) || (seq_req_i.wr && s_cfg1);
    wire wr2 = (host_req_i.wr && h_cfg2) || (seq_req_i.wr && s_cfg2);
    wire wrc = (host_req_i.wr && h_clr) || (seq_req_i.wr && s_clr);
    wire [15:0] wdat0 = (host_req_i.wr && h_cfg0) ? host_req_i.wdata[15:0]
                                                  : seq_req_i.wdata[15:0];
    wire [15:0] wdat1 = (host_req_i.wr && h_cfg1) ? host_req_i.wdata[15:0]
                                                  : seq_req_i.wdata[15:0];
    wire [15:0] wdat2 = (host_req_i.wr && h_cfg2) ? host_req_i.wdata[15:0]
                                                  : seq_req_i.wdata[15:0];
    wire [15:0] wdatc = (host_req_i.wr && h_clr) ? host_req_i.wdata[15:0]
                                                 : seq_req_i.wdata[15:0];

    // Register writes
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ext_irq_cfg0 <= `CEI_RST_CFG;
            ext_irq_cfg1 <= `CEI_RST_CFG;
            ext_irq_cfg2 <= `CEI_RST_CFG;
            ext_irq_clear <= `CEI_RST_CLR;
        end else begin
            if (wr0) begin
                ext_irq_cfg0 <= wdat0;
            end
            if (wr1) begin
                ext_irq_cfg1 <= wdat1;
            end
            if (wr2) begin
                ext_irq_cfg2 <= wdat2;
            end
            if (wrc) begin
                ext_irq_clear <= wdatc;
            end
        end
    end

    // Custom bits: sequencer write of one sets; host write does nothing.
    // Bits stay set until reset since the clear path lies elsewhere.
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            custom_irq_trigger <= 4'h0;
        end else begin
            custom_irq_trigger <= custom_irq_trigger | trig_set;
        end
    end

    // Read mux, host port; trigger read returns zero, which has no meaning
    wire [31:0] h_rd = h_cfg0 ? {16'h0000, ext_irq_cfg0} :
                       h_cfg1 ? {16'h0000, ext_irq_cfg1} :
                       h_cfg2 ? {16'h0000, ext_irq_cfg2} :
                       h_clr ? {16'h0000, ext_irq_clear} : 32'h00000000;
    wire [31:0] s_rd = s_cfg0 ? {16'h0000, ext_irq_cfg0} :
                       s_cfg1 ? {16'h0000, ext_irq_cfg1} :
                       s_cfg2 ? {16'h0000, ext_irq_cfg2} :
                       s_clr ? {16'h0000, ext_irq_clear} :
                       s_trig ? trig_word : 32'h00000000;

    // Read data registered one cycle after the read strobe
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata_o <= 32'h00000000;
            seq_rdata_o <= 32'h00000000;
        end else begin
            if (host_req_i.rd) begin
                host_rdata_o <= h_rd;
            end
            if (seq_req_i.rd) begin
                seq_rdata_o <= s_rd;
            end
        end
    end

    // Flattened config: pin n sits in nibble n of the 48-bit bank
    wire [47:0] cfg_bank = {ext_irq_cfg2, ext_irq_cfg1, ext_irq_cfg0};

    // Per-pin synchroniser, edge and level detect
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] prev;
    logic [11:0] next_irq;
    genvar gi;
    generate
        for (gi = 0; gi < `CEI_NUM_PINS; gi++) begin : g_pin
            wire en = cfg_bank[4 * gi + 3];
            wire [2:0] md = cfg_bank[4 * gi +: 3];
            wire rise = sync2[gi] && !prev[gi];
            wire fall = !sync2[gi] && prev[gi];
            logic hit;
            // Trigger select with aliased upper codes
            always_comb begin
                case (cei_mode_t'(md))
                    CEI_RISE: hit = rise;
                    CEI_FALL, CEI_FALL_A: hit = fall;
                    CEI_BOTH, CEI_BOTH_A: hit = rise || fall;
                    CEI_HIGH, CEI_HIGH_A: hit = sync2[gi];
                    CEI_LOW: hit = !sync2[gi];
                    default: hit = 1'b0;
                endcase
            end
            assign next_irq[gi] = en && hit;
        end
    endgenerate

    // Two-stage synchroniser then one history stage
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 12'h000;
            sync2 <= 12'h000;
            prev <= 12'h000;
            ext_irq_o <= 12'h000;
        end else begin
            sync1 <= gpio_i;
            sync2 <= sync1;
            prev <= sync2;
            ext_irq_o <= next_irq;
        end
    end

    // Any enabled pin event may wake the device
    assign wake_o = |ext_irq_o;
    assign soft_irq_o = custom_irq_trigger;
    assign flag_custom_o = custom_irq_trigger[2:0];

    // Assertions
    host_no_trig_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (host_req_i.wr && !trig_wr) |=> custom_irq_trigger == $past(custom_irq_trigger))
        else $error("host write altered custom bits");
    seq_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (trig_wr && seq_req_i.wdata[0]) |=> ##[0:3] soft_irq_o[0])
        else $error("custom bit not raised");
    trig_word_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (seq_req_i.rd && s_trig) |=> seq_rdata_o[31:4] == 28'h0000001)
        else $error("reserved field wrong");
    clr_rst_a: assert property (@(posedge core_clk_i)
        $rose(rst_n) |-> ext_irq_clear == 16'hc000)
        else $error("clear register reset wrong");
    cfg_rst_a: assert property (@(posedge core_clk_i)
        $rose(rst_n) |-> cfg_bank == 48'h0)
        else $error("config reset wrong");
    dis_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        !$past(cfg_bank[3]) |-> !ext_irq_o[0])
        else $error("disabled pin fired");
    rise_det_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (cfg_bank[3:0] == 4'h8 && sync2[0] && !prev[0]) |=> ext_irq_o[0])
        else $error("rising edge missed");
    high_alias_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (cfg_bank[3:0] == 4'hf && sync2[0]) |=> ext_irq_o[0])
        else $error("high alias missed");
    flag_map_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (trig_wr && seq_req_i.wdata[0]) |=> flag_custom_o[0])
        else $error("flag mapping wrong");
    sync_path_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (cfg_bank[3:0] == 4'hb && $rose(gpio_i[0])) |-> ##3 ext_irq_o[0])
        else $error("sync latency wrong");

    // Read side: the host gets zero where the trigger register sits,
    // so host software cannot learn the custom bits from that read
    host_trig_rd_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (host_req_i.rd && host_req_i.addr == `CEI_OFS_TRIG) |=> host_rdata_o == 32'h0)
        else $error("host trigger read not zero");
    // Unmapped host reads give zero too
    host_unmap_rd_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (host_req_i.rd && host_req_i.addr == 16'h0000) |=> host_rdata_o == 32'h0)
        else $error("unmapped read not zero");

    // Write side: every host write to a config or clear register lands one cycle later
    cfg0_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (host_req_i.wr && h_cfg0) |=> ext_irq_cfg0 == $past(host_req_i.wdata[15:0]))
        else $error("config0 write lost");
    cfg1_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (host_req_i.wr && h_cfg1) |=> ext_irq_cfg1 == $past(host_req_i.wdata[15:0]))
        else $error("config1 write lost");
    cfg2_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (host_req_i.wr && h_cfg2) |=> ext_irq_cfg2 == $past(host_req_i.wdata[15:0]))
        else $error("config2 write lost");
    clr_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (host_req_i.wr && h_clr) |=> ext_irq_clear == $past(host_req_i.wdata[15:0]))
        else $error("clear write lost");
    // Sequencer writes land when the host is not writing the same register
    seq_cfg_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (seq_req_i.wr && s_cfg0 && !(host_req_i.wr && h_cfg0))
        |=> ext_irq_cfg0 == $past(seq_req_i.wdata[15:0]))
        else $error("sequencer config write lost");
    // A collision keeps the host value, so host setup is never silently lost
    host_wins_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (host_req_i.wr && h_cfg0 && seq_req_i.wr && s_cfg0)
        |=> ext_irq_cfg0 == $past(host_req_i.wdata[15:0]))
        else $error("host did not win collision");

    // Custom bits are sticky: no cycle may drop a set bit
    soft_sticky_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (custom_irq_trigger & $past(custom_irq_trigger)) == $past(custom_irq_trigger))
        else $error("custom bit dropped");
    // Every bit written as one is set on the next cycle
    soft_set_all_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        trig_wr |=> (custom_irq_trigger & $past(seq_req_i.wdata[3:0]))
        == $past(seq_req_i.wdata[3:0]))
        else $error("custom bit not set");

    // Trigger decode on pin 0 for the fall, low, rise and either-edge mode families
    fall_det_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (cfg_bank[3:0] == 4'h9 && !sync2[0] && prev[0]) |=> ext_irq_o[0])
        else $error("falling edge missed");
    low_det_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (cfg_bank[3:0] == 4'hc && !sync2[0]) |=> ext_irq_o[0])
        else $error("low level missed");
    rise_only_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (cfg_bank[3:0] == 4'h8 && !(sync2[0] && !prev[0])) |=> !ext_irq_o[0])
        else $error("rising mode fired without edge");
    both_alias_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (cfg_bank[3:0] == 4'he && sync2[0] != prev[0]) |=> ext_irq_o[0])
        else $error("either edge alias missed");
    fall_alias_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (cfg_bank[3:0] == 4'hd && !sync2[0] && prev[0]) |=> ext_irq_o[0])
        else $error("falling alias missed");

    // Nibble layout at the corners of each register
    pin3_map_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (ext_irq_cfg0[15:12] == 4'hb && sync2[3]) |=> ext_irq_o[3])
        else $error("pin 3 layout wrong");
    pin4_map_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (ext_irq_cfg1[3:0] == 4'hb && sync2[4]) |=> ext_irq_o[4])
        else $error("pin 4 layout wrong");
    pin7_map_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (ext_irq_cfg1[15:12] == 4'hb && sync2[7]) |=> ext_irq_o[7])
        else $error("pin 7 layout wrong");
    pin8_map_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (ext_irq_cfg2[3:0] == 4'hb && sync2[8]) |=> ext_irq_o[8])
        else $error("pin 8 layout wrong");
    pin11_map_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (ext_irq_cfg2[15:12] == 4'hb && sync2[11]) |=> ext_irq_o[11])
        else $error("pin 11 layout wrong");
    // Disabled pin 0 stays quiet even at a level that would match
    dis_level_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (cfg_bank[3:0] == 4'h3 && sync2[0]) |=> !ext_irq_o[0])
        else $error("disabled level fired");

    // Main scenarios
    seq_write_c: cover property (@(posedge core_clk_i) disable iff (!rst_n) trig_wr);
    soft_all_c: cover property (@(posedge core_clk_i) disable iff (!rst_n) soft_irq_o == 4'hf);
    pin_fire_c: cover property (@(posedge core_clk_i) disable iff (!rst_n) ext_irq_o[7]);
    wake_c: cover property (@(posedge core_clk_i) disable iff (!rst_n) $rose(wake_o));
endmodule : cei_top
`default_nettype wire

// *** tb/cei_gpio_model.sv ***
// Pin-side model that drives the external interrupt inputs
`timescale 1ns/1ps
`default_nettype none
module cei_gpio_model (
    input wire logic core_clk_i,
    input wire logic [11:0] level_i,
    output logic [11:0] gpio_o
);
    // Levels move just after a rising edge and then hold, like a driven pin.
    // The first edge loads the idle low level while the design is still in reset.
    always @(posedge core_clk_i) begin
        gpio_o <= level_i;
    end
endmodule // cei_gpio_model
`default_nettype wire

// *** tb/custom_and_external_irq_config_bench.sv ***
// Self-checking bench for the custom and external interrupt block
`timescale 1ns/1ps
`default_nettype none
module custom_and_external_irq_config_bench;
    import cei_pkg::*;
    logic core_clk_i = 1'b0; // 25 MHz system clock
    logic nrst_i = 1'b0; // Held low at start
    cei_req_t host_req = '0;
    cei_req_t seq_req = '0;
    logic [11:0] pin_lvl = 12'h000; // Level asked of the pin model
    logic [11:0] gpio;
    logic [31:0] host_rdata;
    logic [31:0] seq_rdata;
    logic [11:0] ext_irq;
    logic wake;
    logic [3:0] soft_irq;
    logic [2:0] flag_custom;
    logic [2:0] m; // Mode code under test
    logic en; // Enable under test
    int miscompares = 0;
    int tests_run = 0;
    int cnt;
    initial forever #20 core_clk_i = ~core_clk_i;
    cei_top u_cei_top (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .host_req_i(host_req),
        .seq_req_i(seq_req), .gpio_i(gpio), .host_rdata_o(host_rdata),
        .seq_rdata_o(seq_rdata), .ext_irq_o(ext_irq), .wake_o(wake),
        .soft_irq_o(soft_irq), .flag_custom_o(flag_custom));
    cei_gpio_model u_cei_gpio_model (.core_clk_i(core_clk_i), .level_i(pin_lvl), .gpio_o(gpio));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One access; the strobe stands for exactly one edge, read data lands after it
    task automatic acc(input bit host, input bit wr, input logic [15:0] a, input logic [31:0] d);
        cei_req_t r;
        r = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge core_clk_i);
        if (host) host_req <= r; else seq_req <= r;
        @(posedge core_clk_i);
        if (host) host_req <= '0; else seq_req <= '0;
        #1;
    endtask
    task automatic pins(input logic [11:0] v);
        @(posedge core_clk_i);
        pin_lvl <= v;
    endtask
    // Counts cycles with the interrupt high; an edge event gives exactly one
    task automatic cnt_irq(input int n);
        cnt = 0;
        repeat (8) begin
            @(posedge core_clk_i);
            #1;
            cnt += (ext_irq[n] === 1'b1);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Cuts a hang short
    initial begin
        repeat (50000) @(posedge core_clk_i);
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        for (int i = 0; i < 3; i++) begin
            acc(1, 0, 16'h0a20 + 16'(4 * i), '0);
            chk("cfg reset", 32'h0, host_rdata);
        end
        acc(1, 0, 16'h0a30, '0);
        chk("clear reset", 32'h0000c000, host_rdata);
        acc(0, 0, 16'h209c, '0);
        chk("trigger reset", 32'h00000010, seq_rdata);
        acc(1, 1, 16'h209c, 32'h0000000f);
        acc(0, 0, 16'h209c, '0);
        chk("trigger after host write", 32'h00000010, seq_rdata);
        chk("soft irq idle", 32'h0, {28'h0, soft_irq});
        acc(1, 0, 16'h209c, '0);
        acc(0, 1, 16'h209c, 32'h00000005);
        chk("soft irq", 32'h5, {28'h0, soft_irq});
        chk("custom flags", 32'h5, {29'h0, flag_custom});
        acc(0, 1, 16'h209c, 32'h0000000a);
        acc(0, 0, 16'h209c, '0);
        chk("trigger bits", 32'h0000001f, seq_rdata);
        acc(1, 1, 16'h0a30, 32'h00001234);
        acc(1, 0, 16'h0a30, '0);
        chk("clear rw", 32'h00001234, host_rdata);
        // Each pin alone at high level, to prove its nibble position
        for (int n = 0; n < 12; n++) begin
            acc(1, 1, 16'h0a20 + 16'(4 * (n / 4)), 32'hb << (4 * (n % 4)));
            pins(12'h001 << n);
            repeat (6) @(posedge core_clk_i);
            #1;
            chk("pin layout", 32'(12'h001 << n), {20'h0, ext_irq});
        end
        pins(12'h000);
        // Every mode code on pin 0, then the same pin disabled
        for (int i = 0; i < 9; i++) begin
            m = i[2:0];
            en = (i < 8);
            acc(1, 1, 16'h0a20, {28'h0, en, m});
            repeat (10) @(posedge core_clk_i);
            pins(12'h001);
            cnt_irq(0);
            if (m[1:0] != 2'h3 && m != 3'h4) chk("rise", 32'(en && m inside {0, 2, 6}), cnt);
            chk("high level", 32'(en && m[1:0] == 2'h3), {31'h0, ext_irq[0]});
            chk("wake high", 32'(en && m[1:0] == 2'h3), {31'h0, wake});
            pins(12'h000);
            cnt_irq(0);
            if (m[1:0] != 2'h3 && m != 3'h4) chk("fall", 32'(en && m inside {1, 2, 5, 6}), cnt);
            chk("low level", 32'(en && m == 3'h4), {31'h0, ext_irq[0]});
        end
        report_and_stop();
    end
endmodule // custom_and_external_irq_config_bench
`default_nettype wire
